// ==== logic/rca_defines.svh ====
// Constants for the receive channel assigner: offsets, resets, timing.
`ifndef RCA_DEFINES_SVH
`define RCA_DEFINES_SVH
`define RCA_NLINK 32
`define RCA_TS_W 5
`define RCA_ACT_W 11
`define RCA_PROV_DEPTH 1024
`define RCA_LB_DEPTH 64
`define RCA_LB_PTR_W 7
`define RCA_NULL_SLOT 2'h3
`define RCA_OFF_CHMODE 8'h00
`define RCA_OFF_THRESH 8'h04
`define RCA_OFF_LOOPBACK 8'h08
`define RCA_OFF_PADDR 8'h0C
`define RCA_OFF_PDATA 8'h10
`define RCA_OFF_STATUS 8'h14
`define RCA_OFF_REQ 8'h18
`define RCA_CHMODE_RST 32'h00000000
`define RCA_THRESH_RST 11'h00C
`define RCA_LOOPBACK_RST 32'h00000000
`define RCA_PW_TSEN_BIT 5
`define RCA_ST_BUSY_BIT 0
`define RCA_ST_LVL_LSB 8
`endif

// ==== logic/rca_pkg.sv ====
// Types shared by the receive channel assigner files.
package rca_pkg;
   typedef enum logic [2:0] {
      RCA_CYC_SERVE = 3'h1,
      RCA_CYC_IDLE = 3'h2,
      RCA_CYC_NULL = 3'h4
   } rca_cycle_t;
   typedef logic [5:0] rca_prov_word_t;
   typedef logic [12:0] rca_lb_word_t;
endpackage

// ==== logic/rca_line_if.sv ====
// One link's line interface: sampling, byte assembly and gap framing.
`timescale 1ns/1ns
`include "rca_defines.svh"
module rca_line_if (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Line pins.
   input wire logic line_clk,
   input wire logic line_data,
   // Configuration.
   input wire logic chan_mode,
   input wire logic [`RCA_ACT_W-1:0] thresh,
   // Service handshake.
   input wire logic ack,
   output logic req,
   output logic [7:0] hold_byte,
   output logic [`RCA_TS_W-1:0] hold_ts
);
   logic clk_s1_q, clk_s2_q, clk_s3_q, dat_s1_q, dat_s2_q;
   logic [2:0] bit_q, bit_d;
   logic [7:0] shift_q, shift_d, hold_q, hold_d;
   logic [`RCA_TS_W-1:0] ts_q, ts_d, hts_q, hts_d;
   logic [`RCA_ACT_W-1:0] act_q, act_d;
   logic req_q, req_d, edge_w, frame_w, byte_w;

   // Data is read with the same two-stage delay as its clock.
   assign edge_w = clk_s2_q & ~clk_s3_q;
   assign frame_w = chan_mode & (act_q == thresh);
   assign byte_w = edge_w & (bit_q == 3'h7);

   always_comb begin
      bit_d = bit_q;
      shift_d = shift_q;
      hold_d = hold_q;
      hts_d = hts_q;
      ts_d = ts_q;
      act_d = act_q;
      if (!chan_mode || edge_w) begin
         act_d = '0;
      end else if (act_q <= thresh) begin
         act_d = act_q + 11'h001;
      end
      if (frame_w) begin
         bit_d = 3'h0;
         ts_d = '0;
      end
      if (edge_w) begin
         shift_d = {shift_q[6:0], dat_s2_q};
         bit_d = bit_q + 3'h1;
         if (byte_w) begin
            hold_d = {shift_q[6:0], dat_s2_q};
            hts_d = ts_q;
            ts_d = ts_q + 5'h01;
         end
      end
      if (!chan_mode) begin
         ts_d = '0;
      end
      // A new byte sets the request even in the cycle it is acknowledged.
      req_d = byte_w | (req_q & ~ack);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_s1_q <= 1'b0;
         clk_s2_q <= 1'b0;
         clk_s3_q <= 1'b0;
         dat_s1_q <= 1'b0;
         dat_s2_q <= 1'b0;
         bit_q <= 3'h0;
         shift_q <= 8'h00;
         hold_q <= 8'h00;
         hts_q <= '0;
         ts_q <= '0;
         act_q <= '0;
         req_q <= 1'b0;
      end else begin
         clk_s1_q <= line_clk;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         dat_s1_q <= line_data;
         dat_s2_q <= dat_s1_q;
         bit_q <= bit_d;
         shift_q <= shift_d;
         hold_q <= hold_d;
         hts_q <= hts_d;
         ts_q <= ts_d;
         act_q <= act_d;
         req_q <= req_d;
      end
   end

   assign req = req_q;
   assign hold_byte = hold_q;
   assign hold_ts = hts_q;
endmodule

// ==== logic/rca_top.sv ====
// Receive channel assigner top: links, priority mux, lookup, loopback, bus.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "rca_defines.svh"
module rca_top (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial links.
   input wire logic [`RCA_NLINK-1:0] rx_line_clk,
   input wire logic [`RCA_NLINK-1:0] rx_line_data,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Loopback transmit bytes.
   input wire logic lb_tx_valid,
   input wire logic [4:0] lb_tx_chan,
   input wire logic [7:0] lb_tx_data,
   output logic lb_tx_ready,
   // Byte stream to the receive frame processor.
   output logic rfp_valid,
   output rca_pkg::rca_cycle_t rfp_kind,
   output logic [4:0] rfp_link,
   output logic [`RCA_TS_W-1:0] rfp_ts,
   output logic [4:0] rfp_chan,
   output logic [7:0] rfp_data
);
   logic [31:0] chmode_q, chmode_d, loop_q, loop_d;
   logic [`RCA_ACT_W-1:0] thr_q, thr_d;
   logic [9:0] paddr_q, paddr_d;
   rca_pkg::rca_prov_word_t pdat_q, pdat_d;
   logic pw_q, pw_d;
   rca_pkg::rca_prov_word_t mem_q [`RCA_PROV_DEPTH];
   logic wr_q, wr_d;
   logic [7:0] wa_q, wa_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0] slot_q, slot_d;
   logic [`RCA_NLINK-1:0] req_w, ack_w;
   logic [7:0] hb_w [`RCA_NLINK];
   logic [`RCA_TS_W-1:0] hts_w [`RCA_NLINK];
   rca_pkg::rca_lb_word_t fifo_q [`RCA_LB_DEPTH];
   logic [`RCA_LB_PTR_W-1:0] wp_q, wp_d, rp_q, rp_d, lvl_w;
   logic push_w, pop_w, empty_w, full_w;
   logic null_w, any_w, lbk_w, take_w;
   logic [4:0] sel_w;
   logic [9:0] look_w;
   rca_pkg::rca_prov_word_t word_w;
   logic v_d, v_q;
   rca_pkg::rca_cycle_t k_d, k_q;
   logic [4:0] l_d, l_q, c_d, c_q;
   logic [`RCA_TS_W-1:0] t_d, t_q;
   logic [7:0] d_d, d_q;

   // An address phase is taken only while the bus is ready.
   function automatic logic rca_take(input logic sel, input logic rdy,
         input logic [1:0] trans);
      return sel & rdy & trans[1];
   endfunction

   // The downward loop lets the lowest pending link win.
   function automatic logic [4:0] rca_first(input logic [31:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            r = i[4:0];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] rca_rdec(input logic [7:0] a,
         input logic [31:0] cm, input logic [31:0] lb,
         input logic [10:0] th, input logic [9:0] pa,
         input logic [5:0] pw, input logic bsy,
         input logic [6:0] lv, input logic [31:0] rq);
      logic [31:0] r;
      r = 32'h00000000;
      case (a)
         `RCA_OFF_CHMODE: r = cm;
         `RCA_OFF_LOOPBACK: r = lb;
         `RCA_OFF_THRESH: r = {21'h000000, th};
         `RCA_OFF_PADDR: r = {22'h000000, pa};
         `RCA_OFF_PDATA: r = {26'h0000000, pw};
         `RCA_OFF_STATUS: r = {17'h00000, lv, 7'h00, bsy};
         `RCA_OFF_REQ: r = rq;
         default: r = 32'h00000000;
      endcase
      return r;
   endfunction

   // Every link has its own line interface and clock synchroniser.
   genvar g;
   generate
      for (g = 0; g < `RCA_NLINK; g++) begin : gen_link
         rca_line_if u_line (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .line_clk(rx_line_clk[g]),
            .line_data(rx_line_data[g]),
            .chan_mode(chmode_q[g]),
            .thresh(thr_q),
            .ack(ack_w[g]),
            .req(req_w[g]),
            .hold_byte(hb_w[g]),
            .hold_ts(hts_w[g])
         );
      end
   endgenerate

   // Bus slave: registers are read in the address phase, written after.
   always_comb begin
      chmode_d = chmode_q;
      loop_d = loop_q;
      thr_d = thr_q;
      paddr_d = paddr_q;
      pdat_d = pdat_q;
      pw_d = pw_q;
      wr_d = rca_take(hsel, hready, htrans) & hwrite;
      wa_d = haddr[7:0];
      rd_d = rd_q;
      if (rca_take(hsel, hready, htrans) && !hwrite) begin
         rd_d = rca_rdec(haddr[7:0], chmode_q, loop_q, thr_q, paddr_q,
            mem_q[paddr_q], pw_q, lvl_w, req_w);
      end
      if (pw_q && null_w) begin
         pw_d = 1'b0;
      end
      if (wr_q) begin
         case (wa_q)
            `RCA_OFF_CHMODE: chmode_d = hwdata;
            `RCA_OFF_LOOPBACK: loop_d = hwdata;
            `RCA_OFF_THRESH: thr_d = hwdata[`RCA_ACT_W-1:0];
            `RCA_OFF_PADDR: paddr_d = hwdata[9:0];
            `RCA_OFF_PDATA: begin
               pdat_d = hwdata[5:0];
               pw_d = 1'b1;
            end
            default: chmode_d = chmode_q;
         endcase
      end
   end

   // Priority mux with a null slot every fourth cycle.
   // A null slot never acknowledges, so a request simply waits a cycle.
   always_comb begin
      slot_d = slot_q + 2'h1;
      null_w = (slot_q == `RCA_NULL_SLOT);
      any_w = |req_w;
      sel_w = rca_first(req_w);
      ack_w = '0;
      if (!null_w && any_w) begin
         ack_w[sel_w] = 1'b1;
      end
      // Unchannelised links use slot zero of their block.
      look_w = chmode_q[sel_w] ? {sel_w, hts_w[sel_w]} : {sel_w, 5'h00};
      word_w = mem_q[look_w];
      lbk_w = ~word_w[`RCA_PW_TSEN_BIT] | loop_q[word_w[4:0]];
      take_w = ~null_w & any_w & lbk_w & ~empty_w;
      v_d = 1'b0;
      k_d = rca_pkg::RCA_CYC_IDLE;
      l_d = sel_w;
      t_d = hts_w[sel_w];
      c_d = word_w[4:0];
      d_d = hb_w[sel_w];
      if (null_w) begin
         k_d = rca_pkg::RCA_CYC_NULL;
      end else if (any_w) begin
         k_d = rca_pkg::RCA_CYC_SERVE;
         v_d = ~lbk_w | take_w;
         if (take_w) begin
            c_d = fifo_q[rp_q[5:0]][12:8];
            d_d = fifo_q[rp_q[5:0]][7:0];
         end
      end
   end

   // Loopback buffer of transmit bytes for loopback channels.
   always_comb begin
      lvl_w = wp_q - rp_q;
      empty_w = (wp_q == rp_q);
      full_w = (lvl_w == 7'h40);
      push_w = lb_tx_valid & loop_q[lb_tx_chan] & ~full_w;
      pop_w = take_w;
      wp_d = push_w ? wp_q + 7'h01 : wp_q;
      rp_d = pop_w ? rp_q + 7'h01 : rp_q;
   end

   // Buffer storage has no reset; only the pointers say what is valid.
   always_ff @(posedge ref_clk) begin
      if (push_w) begin
         fifo_q[wp_q[5:0]] <= {lb_tx_chan, lb_tx_data};
      end
   end

   // Provisioning writes wait for the null slot so lookups never collide.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `RCA_PROV_DEPTH; i++) begin
            mem_q[i] <= 6'h00;
         end
      end else if (pw_q && null_w) begin
         mem_q[paddr_q] <= pdat_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chmode_q <= `RCA_CHMODE_RST;
         loop_q <= `RCA_LOOPBACK_RST;
         thr_q <= `RCA_THRESH_RST;
         paddr_q <= 10'h000;
         pdat_q <= 6'h00;
         pw_q <= 1'b0;
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         rd_q <= 32'h00000000;
      end else begin
         chmode_q <= chmode_d;
         loop_q <= loop_d;
         thr_q <= thr_d;
         paddr_q <= paddr_d;
         pdat_q <= pdat_d;
         pw_q <= pw_d;
         wr_q <= wr_d;
         wa_q <= wa_d;
         rd_q <= rd_d;
      end
   end

   // Pointers carry a spare bit so a full buffer differs from an empty one.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 7'h00;
         rp_q <= 7'h00;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end

   // Stream outputs are registered so the frame processor sees clean data.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_q <= 2'h0;
         v_q <= 1'b0;
         k_q <= rca_pkg::RCA_CYC_IDLE;
         l_q <= 5'h00;
         t_q <= 5'h00;
         c_q <= 5'h00;
         d_q <= 8'h00;
      end else begin
         slot_q <= slot_d;
         v_q <= v_d;
         k_q <= k_d;
         l_q <= l_d;
         t_q <= t_d;
         c_q <= c_d;
         d_q <= d_d;
      end
   end

   // The bus never stalls, so the transfer size is not checked.
   assign hrdata = rd_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign lb_tx_ready = ~full_w;
   assign rfp_valid = v_q;
   assign rfp_kind = k_q;
   assign rfp_link = l_q;
   assign rfp_ts = t_q;
   assign rfp_chan = c_q;
   assign rfp_data = d_q;
endmodule

// ==== dv/rca_chk.sv ====
// Port checker for the receive channel assigner.
`timescale 1ns/1ns
`include "rca_defines.svh"
module rca_chk (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register bus.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Byte stream.
   input wire logic rfp_valid,
   input rca_pkg::rca_cycle_t rfp_kind,
   input wire logic [4:0] rfp_link,
   input wire logic [`RCA_TS_W-1:0] rfp_ts
);
   logic rd_a, wr_q;
   logic [31:0] chm_q;
   assign rd_a = hsel && hready && htrans[1] && !hwrite;
   // The checker sees no registers, so mode bits are mirrored from writes.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'b0;
         chm_q <= 32'h00000000;
      end else begin
         wr_q <= hsel && hready && htrans[1] && hwrite &&
            haddr[7:0] == `RCA_OFF_CHMODE;
         if (wr_q) begin
            chm_q <= hwdata;
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_gap3;
      (rfp_kind != rca_pkg::RCA_CYC_NULL) [*3];
   endsequence
   a_null_period: assert property (
      rfp_kind == rca_pkg::RCA_CYC_NULL |=> s_gap3 ##1
      rfp_kind == rca_pkg::RCA_CYC_NULL)
      else $error("null slot out of step");
   a_valid_serve: assert property (
      rfp_valid |-> rfp_kind == rca_pkg::RCA_CYC_SERVE)
      else $error("valid outside a serve");
   a_kind_onehot: assert property ($onehot(rfp_kind))
      else $error("kind not one-hot");
   a_one_link: assert property (
      rfp_valid ##1 rfp_valid |-> rfp_link != $past(rfp_link))
      else $error("link served twice running");
   a_unch_ts: assert property (
      rfp_valid && !chm_q[rfp_link] |-> rfp_ts == 5'h00)
      else $error("slot on unchannelised link");
   a_rdata_hold: assert property (!rd_a |=> $stable(hrdata))
      else $error("read data moved");
   a_unmapped: assert property (
      rd_a && haddr[7:0] > `RCA_OFF_REQ |=> hrdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
endmodule
bind rca_top rca_chk u_chk (.ref_clk, .rst_n, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rfp_valid,
   .rfp_kind, .rfp_link, .rfp_ts);

// ==== dv/rca_line_src.sv ====
// Serial line source model for one link.
`timescale 1ns/1ns
module rca_line_src #(
   // 1.25 MHz, inside every link rate limit.
   parameter int HALF_NS = 400
) (
   // Line pins.
   output logic lclk,
   output logic ldata
);
   initial begin
      lclk = 1'b0;
      ldata = 1'b0;
   end
   // The clock stands low between calls; a long pause is a framing gap.
   task automatic send(input logic [7:0] b, input int nbits);
      #13;
      for (int i = 7; i > 7 - nbits; i--) begin
         ldata = b[i];
         #HALF_NS lclk = 1'b1;
         #HALF_NS lclk = 1'b0;
      end
      ldata = ~ldata;
   endtask
endmodule

// ==== dv/test_rca_top.sv ====
// Self-checking bench for the receive channel assigner.
`timescale 1ns/1ns
module test_rca_top;
   logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, lb_tx_valid = 1'b0, lb_tx_ready, rfp_valid;
   logic [4:0] lb_tx_chan = 5'h00, rfp_link, rfp_ts, rfp_chan;
   logic [7:0] lb_tx_data = 8'h00, rfp_data;
   rca_pkg::rca_cycle_t rfp_kind;
   logic c0, d0, c1, d1;
   logic [22:0] got[$];
   int fail_count = 0, n_tests = 0;
   always #50 ref_clk = ~ref_clk;
   rca_line_src src0 (.lclk(c0), .ldata(d0));
   rca_line_src src1 (.lclk(c1), .ldata(d1));
   // Two live links are enough to show the service order.
   rca_top dut (
      .ref_clk, .rst_n,
      .rx_line_clk({30'h0, c1, c0}), .rx_line_data({30'h0, d1, d0}),
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .lb_tx_valid, .lb_tx_chan, .lb_tx_data, .lb_tx_ready,
      .rfp_valid, .rfp_kind, .rfp_link, .rfp_ts, .rfp_chan, .rfp_data);
   always @(posedge ref_clk) begin
      if (rfp_valid === 1'b1) begin
         got.push_back({rfp_link, rfp_ts, rfp_chan, rfp_data});
      end
   end
   task automatic give_verdict;
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      fail_count++;
      give_verdict;
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rdv);
      @(posedge ref_clk);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsel <= 1'b1;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rdv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check("register", x, exp);
   endtask
   task automatic prov(input logic [9:0] a, input logic [5:0] w);
      logic [31:0] x;
      wr(8'h0C, {22'h0, a});
      wr(8'h10, {26'h0, w});
      x = 32'h1;
      for (int n = 0; n < 20 && x[0]; n++) bus(1'b0, 8'h14, 32'h0, x);
      check("pending", x & 32'h1, 32'h0);
      rd(8'h10, {26'h0, w});
   endtask
   task automatic expect_byte(input logic [22:0] exp);
      for (int n = 0; n < 50 && got.size() == 0; n++) @(posedge ref_clk);
      if (got.size() == 0) got.push_back(23'h7FFFFF);
      check("byte", {9'h0, got.pop_front()}, {9'h0, exp});
   endtask
   task automatic t_regs;
      rd(8'h04, 32'h0000000C);
      rd(8'h00, 32'h0);
      rd(8'h1C, 32'h0);
      prov(10'h000, 6'h25);
      prov(10'h020, 6'h29);
      prov(10'h001, 6'h27);
   endtask
   task automatic t_unch;
      src0.send(8'hA5, 8);
      expect_byte({10'h000, 5'h05, 8'hA5});
   endtask
   task automatic t_prio;
      fork
         src1.send(8'h22, 8);
         src0.send(8'h11, 8);
      join
      expect_byte({10'h000, 5'h05, 8'h11});
      expect_byte({10'h020, 5'h09, 8'h22});
   endtask
   task automatic t_chan;
      wr(8'h00, 32'h1);
      // Lets the activity counter pass the threshold before data starts.
      repeat (20) @(posedge ref_clk);
      src0.send(8'h3C, 8);
      src0.send(8'hC3, 8);
      #3000 src0.send(8'h12, 3);
      #3000 src0.send(8'h5A, 8);
      expect_byte({10'h000, 5'h05, 8'h3C});
      expect_byte({10'h001, 5'h07, 8'hC3});
      expect_byte({10'h000, 5'h05, 8'h5A});
      wr(8'h00, 32'h0);
   endtask
   task automatic t_loop;
      wr(8'h08, 32'h20);
      @(posedge ref_clk);
      lb_tx_valid <= 1'b1;
      lb_tx_chan <= 5'h05;
      lb_tx_data <= 8'h77;
      @(posedge ref_clk);
      check("lb_ready", {31'h0, lb_tx_ready}, 32'h1);
      lb_tx_chan <= 5'h06;
      @(posedge ref_clk);
      lb_tx_valid <= 1'b0;
      rd(8'h14, 32'h00000100);
      src0.send(8'hA5, 8);
      expect_byte({10'h000, 5'h05, 8'h77});
      rd(8'h14, 32'h0);
      // With the buffer empty a loopback byte is dropped, not passed on.
      src0.send(8'h5A, 8);
      repeat (20) @(posedge ref_clk);
      check("dropped", got.size(), 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs;
      t_unch;
      t_prio;
      t_chan;
      t_loop;
      give_verdict;
   end
endmodule
